/* File: dsp_core_datapath.sv */
// accumulator, multiplier, scalers, address unit, ram decode, interrupt flags
// and program address logic; assumes commands come from a decoder on clk_sys
//
// Function
// RQ1 - enabled interrupt wakes core from light idle
// RQ2 - halt mode left only by reset
// RQ3 - 32-bit accumulator with shift and rotate
// RQ4 - unsigned 16-bit address arithmetic unit
// RQ5 - eight aux pointers, pointer zero as step
// RQ6 - bus request during global access, ready completes
// RQ7 - global space extends data by 32K
// RQ8 - carry stored, fed back, used in shifts
// RQ9 - 32-bit single-cycle central arithmetic unit
// RQ10 - config bit maps block zero data/program
// RQ11 - blocks one and two fixed data decode
// RQ12 - blocks zero, one 256 words; two 32
// RQ13 - direct address is page pointer plus offset
// RQ14 - size register sets global memory space
// RQ15 - seven mask bits enable each interrupt
// RQ16 - seven flag bits latch pending interrupts
// RQ17 - thirty-two trap vectors, hardware and software
// RQ18 - input scaler shifts 0 to 16 left
// RQ19 - signed/unsigned 16x16 multiply in one cycle
// RQ20 - output scaler 0 to 7, pick half
// RQ21 - program address held until bus cycle done
// RQ22 - counter increments next program address
// RQ23 - product scaler left 0,1,4 or right 6
// RQ24 - return stack 16 bits, eight deep
//
// The address map and the plain strobed port were decided locally.
`default_nettype none
module dsp_core_datapath
    import dsp_core_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire core_cmd_t         cmd,
    input  wire logic [WORD_W-1:0] data_in,
    input  wire logic [WORD_W-1:0] mpy_a,
    input  wire logic [WORD_W-1:0] mpy_b,
    input  wire logic [NUM_IRQ-1:0] irq_pin,
    input  wire logic              global_ready_pin,
    input  wire logic [RADR_W-1:0] reg_addr,
    input  wire logic [WORD_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [WORD_W-1:0]      reg_rdata,
    output logic [WORD_W-1:0]      data_write_bus,
    output logic [WORD_W-1:0]      data_read,
    output logic [WORD_W-1:0]      data_addr,
    output logic [WORD_W-1:0]      prog_address_bus,
    output logic [WORD_W-1:0]      prog_word,
    output logic                   global_bus_request,
    output logic                   global_write,
    output logic                   cpu_clk_en,
    output logic                   alu_zero,
    output logic                   alu_neg,
    output logic                   carry_out,
    output logic                   irq_taken
);
    // ====================================================
    // synchronisers for pins
    logic [NUM_IRQ-1:0] irq_meta, irq_s;
    logic               rdy_meta, rdy_s, rdy_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_meta <= '0;
            irq_s    <= '0;
            rdy_meta <= 1'b0;
            rdy_s    <= 1'b0;
            rdy_q    <= 1'b0;
        end else begin
            irq_meta <= irq_pin;
            irq_s    <= irq_meta;
            rdy_meta <= global_ready_pin;
            rdy_s    <= rdy_meta;
            rdy_q    <= rdy_s;
        end
    end

    // ====================================================
    // control registers
    logic               ram_block_config_bit, intm;
    logic [1:0]         lpm;
    logic [NUM_IRQ-1:0] irq_mask_reg, irq_flag_reg;
    logic [7:0]         global_mem_size_reg;
    logic [ACC_W-1:0]   accumulator_reg;
    logic               carry, cmp_flag;
    logic [2:0]         aux_pointer_select;
    power_state_t       pw_state;
    logic               run, stall, take;
    logic [2:0]         take_idx;
    logic [NUM_IRQ-1:0] pend;
    wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ram_block_config_bit <= 1'b0;
            lpm                  <= 2'b00;
            irq_mask_reg         <= '0;
            global_mem_size_reg  <= GSIZE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ram_block_config_bit <= reg_wdata[0]; // RQ10
                lpm                  <= reg_wdata[3:2];
            end
            if (reg_addr == REG_MASK)
                irq_mask_reg <= reg_wdata[NUM_IRQ-1:0]; // RQ15
            if (reg_addr == REG_GSIZE)
                global_mem_size_reg <= reg_wdata[7:0]; // RQ14
        end
    end

    // ====================================================
    // interrupt flags: pin set beats both write-one-clear and take
    assign pend = irq_flag_reg & irq_mask_reg;
    always_comb begin
        take_idx = 3'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--)
            if (pend[i])
                take_idx = 3'(i);
    end
    assign take = run && !stall && !intm && (pend != '0);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_flag_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_IRQ; i++) begin
                if (irq_s[i])
                    irq_flag_reg[i] <= 1'b1; // RQ16
                else if ((reg_wr && reg_addr == REG_FLAG && reg_wdata[i]) ||
                         (take && take_idx == 3'(i)))
                    irq_flag_reg[i] <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            intm <= 1'b1;
        else if (take || (run && !stall && cmd.trap_go))
            intm <= 1'b1;
        else if (wr_ctrl)
            intm <= reg_wdata[1];
    end

    // ====================================================
    // power modes
    wire wake = (pend != '0) && !intm;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pw_state <= PW_RUN;
        end else begin
            case (pw_state)
                PW_RUN:   if (cmd.idle_req && !stall)
                              pw_state <= lpm[1] ? PW_HALT : PW_LIGHT;
                PW_LIGHT: if (wake)
                              pw_state <= PW_RUN; // RQ1
                PW_HALT:  pw_state <= PW_HALT; // RQ2
                default:  pw_state <= PW_RUN;
            endcase
        end
    end
    assign run = (pw_state == PW_RUN);
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            cpu_clk_en <= 1'b1;
        else
            cpu_clk_en <= (pw_state == PW_LIGHT) ? wake :
                          (pw_state == PW_RUN) && !(cmd.idle_req && !stall);
    end

    // ====================================================
    // scalers and multiplier
    logic [ACC_W-1:0] iscaled, product, pscaled, opd, oscaled;
    wire [ACC_W-1:0] din_ext = {{WORD_W{cmd.sign_ext & data_in[WORD_W-1]}}, data_in};
    wire [4:0] ish = (cmd.ishift > 5'd16) ? 5'd16 : cmd.ishift;
    assign iscaled = din_ext << ish; // RQ18
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            product <= '0;
        else if (run && !stall && cmd.mpy_go)
            product <= cmd.mpy_signed ? // RQ19
                       ACC_W'($signed(mpy_a)) * ACC_W'($signed(mpy_b)) : ACC_W'(mpy_a) * ACC_W'(mpy_b);
    end
    always_comb begin
        case (cmd.pmode) // RQ23
            PS_L1:   pscaled = product << 1;
            PS_L4:   pscaled = product << 4;
            PS_R6:   pscaled = ACC_W'($signed(product) >>> 6);
            default: pscaled = product;
        endcase
    end
    assign opd     = cmd.src_prod ? pscaled : iscaled;
    assign oscaled = accumulator_reg << cmd.oshift;
    wire [WORD_W-1:0] next_dwb = cmd.out_high ? oscaled[ACC_W-1:WORD_W] :
                                                oscaled[WORD_W-1:0]; // RQ20

    // ====================================================
    // central arithmetic unit
    logic [ACC_W-1:0] next_acc;
    logic             next_carry;
    logic [ACC_W:0]   sum;
    always_comb begin
        next_acc   = accumulator_reg;
        next_carry = carry;
        sum        = '0;
        case (cmd.alu_op) // RQ9
            ALU_LOAD: next_acc = opd;
            ALU_ADD, ALU_ADDC: begin
                sum = {1'b0, accumulator_reg} + {1'b0, opd} +
                      {{ACC_W{1'b0}}, cmd.alu_op == ALU_ADDC && carry}; // RQ8
                next_acc   = sum[ACC_W-1:0];
                next_carry = sum[ACC_W];
            end
            ALU_SUB, ALU_SUBB: begin
                sum = {1'b0, accumulator_reg} + {1'b0, ~opd} +
                      {{ACC_W{1'b0}}, cmd.alu_op == ALU_SUB || carry};
                next_acc   = sum[ACC_W-1:0];
                next_carry = sum[ACC_W];
            end
            ALU_AND: next_acc = accumulator_reg & opd;
            ALU_OR:  next_acc = accumulator_reg | opd;
            ALU_XOR: next_acc = accumulator_reg ^ opd;
            ALU_SFL: {next_carry, next_acc} = {accumulator_reg, 1'b0}; // RQ3
            ALU_SFR: {next_acc, next_carry} = {1'b0, accumulator_reg};
            ALU_ROL: {next_carry, next_acc} = {accumulator_reg, carry};
            ALU_ROR: {next_acc, next_carry} = {carry, accumulator_reg};
            default: ;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            accumulator_reg <= '0;
            carry           <= 1'b0;
        end else if (run && !stall) begin
            accumulator_reg <= next_acc; // RQ3
            carry           <= next_carry; // RQ8
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            data_write_bus <= '0;
            alu_zero       <= 1'b1;
            alu_neg        <= 1'b0;
            carry_out      <= 1'b0;
        end else begin
            data_write_bus <= next_dwb;
            alu_zero       <= (run && !stall ? next_acc : accumulator_reg) == '0;
            alu_neg        <= run && !stall ? next_acc[ACC_W-1] : accumulator_reg[ACC_W-1];
            carry_out      <= run && !stall ? next_carry : carry;
        end
    end

    // ====================================================
    // auxiliary pointers and address unit
    logic [WORD_W-1:0] aux_reg [NUM_AUX];
    wire  [WORD_W-1:0] aux_pointer_zero = aux_reg[0];
    wire  [WORD_W-1:0] aux_cur = aux_reg[aux_pointer_select];
    logic [WORD_W-1:0] address_arith_unit;
    always_comb begin
        case (cmd.aru_op) // RQ4
            ARU_INC:  address_arith_unit = aux_cur + 16'h0001;
            ARU_DEC:  address_arith_unit = aux_cur - 16'h0001;
            ARU_ADD0: address_arith_unit = aux_cur + aux_pointer_zero; // RQ5
            ARU_SUB0: address_arith_unit = aux_cur - aux_pointer_zero;
            ARU_LOAD: address_arith_unit = data_in;
            default:  address_arith_unit = aux_cur;
        endcase
    end
    wire aru_wr = run && !stall && cmd.aru_op != ARU_NONE && cmd.aru_op != ARU_CMP;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_AUX; i++)
                aux_reg[i] <= '0;
            aux_pointer_select <= 3'h0;
            cmp_flag           <= 1'b0;
        end else if (run && !stall) begin
            if (aru_wr)
                aux_reg[aux_pointer_select] <= address_arith_unit; // RQ4
            if (cmd.aru_op == ARU_CMP)
                cmp_flag <= aux_cur == aux_pointer_zero; // RQ5
            if (cmd.arp_load)
                aux_pointer_select <= cmd.arp_val; // RQ5
        end
    end

    // ====================================================
    // page pointer and data address
    logic [PAGE_W-1:0] page_pointer;
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            page_pointer <= '0;
        else if (run && !stall && cmd.dp_load)
            page_pointer <= cmd.dp_val; // RQ13
    end
    wire [WORD_W-1:0] eff_addr = cmd.direct ? {page_pointer, cmd.ir_low} : aux_cur; // RQ13

    // ====================================================
    // dual access ram blocks and global space decode
    logic [WORD_W-1:0] ram_block_zero [B01_WORDS];
    logic [WORD_W-1:0] ram_one        [B01_WORDS];
    logic [WORD_W-1:0] ram_two        [B2_WORDS];
    wire hit0 = !ram_block_config_bit && eff_addr[15:8] == B0_DATA_BASE[15:8]; // RQ10
    wire hit1 = eff_addr[15:8] == B1_BASE[15:8]; // RQ11
    wire hit2 = eff_addr[15:5] == B2_BASE[15:5]; // RQ11
    wire [7:0] gfloor = (global_mem_size_reg < GLOBAL_FLOOR) ? GLOBAL_FLOOR : global_mem_size_reg;
    wire hitg = eff_addr[15] && (eff_addr[15:8] >= gfloor); // RQ7 RQ14
    wire mem_do = run && !stall && cmd.mem_go;
    wire [WORD_W-1:0] next_prog_addr_reg_in_b0;
    always_ff @(posedge clk_sys) begin
        if (mem_do && cmd.mem_write) begin
            if (hit0)
                ram_block_zero[eff_addr[7:0]] <= next_dwb; // RQ12
            if (hit1)
                ram_one[eff_addr[7:0]] <= next_dwb;
            if (hit2)
                ram_two[eff_addr[4:0]] <= next_dwb;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            data_read <= '0;
        else if (mem_do && !cmd.mem_write)
            data_read <= hit0 ? ram_block_zero[eff_addr[7:0]] :
                         hit1 ? ram_one[eff_addr[7:0]] :
                         hit2 ? ram_two[eff_addr[4:0]] : '0;
        else if (global_bus_request && rdy_s && !rdy_q && !global_write)
            data_read <= data_in;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            global_bus_request <= 1'b0;
            global_write       <= 1'b0;
            data_addr          <= '0;
        end else if (global_bus_request) begin
            if (rdy_s && !rdy_q)
                global_bus_request <= 1'b0; // RQ6
        end else if (mem_do) begin
            data_addr          <= eff_addr;
            global_bus_request <= hitg; // RQ6
            global_write       <= cmd.mem_write;
        end
    end
    // a cycle that started a global access stalls until ready retires it
    assign stall = global_bus_request;

    // ====================================================
    // program address, counter and return stack
    logic [WORD_W-1:0] next_prog_addr_reg, prog_addr_hold_reg;
    logic [WORD_W-1:0] stack_mem [STK_DEP];
    logic [2:0]        sp;
    wire  [WORD_W-1:0] pc_inc = next_prog_addr_reg + 16'h0001; // RQ22
    wire  [4:0]        vec = cmd.trap_go ? cmd.trap_num : 5'(take_idx + 3'h1); // RQ17
    wire  vec_go = take || (run && cmd.trap_go);
    wire  push   = run && !stall && (vec_go || cmd.call);
    wire  pop    = run && !stall && !vec_go && cmd.ret;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            next_prog_addr_reg <= '0;
            prog_addr_hold_reg <= '0;
            sp                 <= 3'h0;
        end else if (run && !stall) begin // RQ21
            prog_addr_hold_reg <= next_prog_addr_reg;
            if (vec_go)
                next_prog_addr_reg <= 16'(vec) * VEC_STRIDE; // RQ17
            else if (cmd.branch || cmd.call)
                next_prog_addr_reg <= cmd.target;
            else if (pop)
                next_prog_addr_reg <= stack_mem[sp - 3'h1];
            else
                next_prog_addr_reg <= pc_inc; // RQ22
            if (push) begin
                stack_mem[sp] <= pc_inc; // RQ24
                sp            <= sp + 3'h1;
            end else if (pop) begin
                sp <= sp - 3'h1; // RQ24
            end
        end
    end
    assign next_prog_addr_reg_in_b0 = next_prog_addr_reg;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prog_address_bus <= '0;
            prog_word        <= '0;
            irq_taken        <= 1'b0;
        end else begin
            irq_taken <= take;
            if (run && !stall) begin
                prog_address_bus <= next_prog_addr_reg; // RQ21
                prog_word <= (ram_block_config_bit && next_prog_addr_reg_in_b0[15:8] == B0_PROG_BASE[15:8]) ?
                             ram_block_zero[next_prog_addr_reg_in_b0[7:0]] : '0; // RQ10
            end
        end
    end

    // ====================================================
    // register read port
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:   reg_rdata <= {12'h000, lpm, intm, ram_block_config_bit};
                REG_MASK:   reg_rdata <= {9'h000, irq_mask_reg};
                REG_FLAG:   reg_rdata <= {9'h000, irq_flag_reg};
                REG_GSIZE:  reg_rdata <= {8'h00, global_mem_size_reg};
                REG_ACC_LO: reg_rdata <= accumulator_reg[WORD_W-1:0];
                REG_ACC_HI: reg_rdata <= accumulator_reg[ACC_W-1:WORD_W];
                REG_STAT:   reg_rdata <= {8'h00, pw_state, aux_pointer_select, cmp_flag, stall, carry};
                default:    reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ====================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_idle_pend;
        pw_state == PW_LIGHT && wake;
    endsequence
    a_halt_sticks: assert property (pw_state == PW_HALT |=> pw_state == PW_HALT) // RQ2
        else $error("halt state left without reset");
    a_light_wakes: assert property (s_idle_pend |=> run ##0 cpu_clk_en) // RQ1
        else $error("enabled interrupt did not wake light idle");
    a_mask_blocks: assert property (pw_state == PW_LIGHT && pend == '0 |=> !run) // RQ15
        else $error("masked interrupt woke core");
    a_flag_latch: assert property (irq_s != '0 |=> (irq_flag_reg & $past(irq_s)) == $past(irq_s)) // RQ16
        else $error("interrupt flag not latched");
    a_req_release: assert property (global_bus_request && rdy_s && !rdy_q |=> !global_bus_request) // RQ6
        else $error("bus request not released after ready");
    a_addr_hold: assert property (stall |=> $stable(prog_address_bus)[*2] or !stall) // RQ21
        else $error("program address moved during stall");
    a_pc_step: assert property (run && !stall && !vec_go && !cmd.branch && !cmd.call && !cmd.ret
        |=> next_prog_addr_reg == $past(next_prog_addr_reg) + 16'h0001) // RQ22
        else $error("program counter did not increment");
    a_acc_add: assert property (run && !stall && cmd.alu_op == ALU_ADD
        |=> accumulator_reg == $past(accumulator_reg) + $past(opd)) // RQ9
        else $error("add result wrong");
    a_direct_addr: assert property (mem_do && cmd.direct && !global_bus_request
        |=> data_addr == {$past(page_pointer), $past(cmd.ir_low)}) // RQ13
        else $error("direct address wrong");
    a_global_top: assert property (global_bus_request |-> data_addr[15]) // RQ7
        else $error("global access below upper 32K");
endmodule
`default_nettype wire

/* File: dsp_core_pkg.sv */
// constants, types and register map of the signal-processing core datapath
// assumes one clock domain and a plain single-cycle register port
`default_nettype none
package dsp_core_pkg;
    // ====================================================
    // widths
    localparam int WORD_W  = 16;
    localparam int ACC_W   = 32;
    localparam int PAGE_W  = 9;
    localparam int OFS_W   = 7;
    localparam int NUM_IRQ = 7;
    localparam int NUM_AUX = 8;
    localparam int STK_DEP = 8;
    localparam int RADR_W  = 3;
    // ====================================================
    // register indices
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_MASK   = 3'h1;
    localparam logic [2:0] REG_FLAG   = 3'h2;
    localparam logic [2:0] REG_GSIZE  = 3'h3;
    localparam logic [2:0] REG_ACC_LO = 3'h4;
    localparam logic [2:0] REG_ACC_HI = 3'h5;
    localparam logic [2:0] REG_STAT   = 3'h6;
    // ====================================================
    // memory map
    localparam logic [15:0] B0_DATA_BASE = 16'h0200;
    localparam logic [15:0] B0_PROG_BASE = 16'hff00;
    localparam logic [15:0] B1_BASE      = 16'h0300;
    localparam logic [15:0] B2_BASE      = 16'h0060;
    localparam int          B01_WORDS    = 256;
    localparam int          B2_WORDS     = 32;
    localparam logic [7:0]  GSIZE_RESET  = 8'h00;
    localparam logic [7:0]  GLOBAL_FLOOR = 8'h80;
    localparam logic [15:0] VEC_STRIDE   = 16'h0002;
    // ====================================================
    // types
    typedef enum logic [1:0] {
        PW_RUN   = 2'b00,
        PW_LIGHT = 2'b01,
        PW_HALT  = 2'b11
    } power_state_t;
    typedef enum logic [3:0] {
        ALU_NOP, ALU_LOAD, ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB, ALU_AND,
        ALU_OR, ALU_XOR, ALU_SFL, ALU_SFR, ALU_ROL, ALU_ROR
    } alu_op_t;
    typedef enum logic [2:0] {
        ARU_NONE, ARU_INC, ARU_DEC, ARU_ADD0, ARU_SUB0, ARU_LOAD, ARU_CMP
    } aru_op_t;
    typedef enum logic [1:0] {
        PS_NONE, PS_L1, PS_L4, PS_R6
    } product_scaler_t;
    typedef struct packed {
        alu_op_t     alu_op;
        logic        src_prod;
        logic        sign_ext;
        logic [4:0]  ishift;
        product_scaler_t     pmode;
        logic        mpy_go;
        logic        mpy_signed;
        logic [2:0]  oshift;
        logic        out_high;
        aru_op_t     aru_op;
        logic        arp_load;
        logic [2:0]  arp_val;
        logic        dp_load;
        logic [8:0]  dp_val;
        logic [6:0]  ir_low;
        logic        mem_go;
        logic        mem_write;
        logic        direct;
        logic        branch;
        logic        call;
        logic        ret;
        logic        trap_go;
        logic [4:0]  trap_num;
        logic        idle_req;
        logic [15:0] target;
    } core_cmd_t;
endpackage
`default_nettype wire

/* File: glob_mem_model.sv */
// global data memory model: answers a bus request with ready after a delay
// assumes the core synchronises ready itself
`default_nettype none
module glob_mem_model (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       global_bus_request,
    input  wire logic [3:0] wait_cycles,
    output logic            global_ready_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================
    // ready answer
    logic [3:0] cnt;
    // ready falls with the request so a stale ready never meets the next access
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !global_bus_request) begin
            cnt <= 4'h0;
            global_ready_pin <= 1'b0;
        end else if (cnt == wait_cycles) begin
            global_ready_pin <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: test_dsp_core_datapath.sv */
// self-checking bench: registers, accumulator, scalers, global access, power
// assumes glob_mem_model answers the global bus request
`default_nettype none
module test_dsp_core_datapath
    import dsp_core_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================
    // signals
    logic        clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
    logic        ready, gbr, cpu_en;
    core_cmd_t   cmd = '0;
    logic [15:0] data_in = '0, reg_wdata = '0, reg_rdata, dwb, drd, dadr, q[$];
    logic [6:0]  irq_pin = '0;
    logic [2:0]  reg_addr = '0;
    logic [3:0]  wait_cycles = 4'h0;
    logic [31:0] seed = 32'd70171;
    int          err_count = 0, num_checks = 0;
    dsp_core_datapath dsp_core_datapath_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd(cmd), .data_in(data_in),
        .mpy_a(data_in), .mpy_b(data_in), .irq_pin(irq_pin), .global_ready_pin(ready), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_write_bus(dwb),
        .data_read(drd), .data_addr(dadr), .prog_address_bus(), .prog_word(), .global_bus_request(gbr),
        .global_write(), .cpu_clk_en(cpu_en), .alu_zero(), .alu_neg(), .carry_out(), .irq_taken());
    glob_mem_model glob_mem_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .global_bus_request(gbr),
        .wait_cycles(wait_cycles), .global_ready_pin(ready));
    initial forever #5 clk_sys = ~clk_sys;
    // ====================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // a read notes its expected value; the watcher below compares it
    task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w) q.push_back(d);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic op(input core_cmd_t c);
        @(posedge clk_sys);
        cmd <= c;
        @(posedge clk_sys);
        cmd <= '0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) rd_seen <= reg_rd;
    always @(negedge clk_sys) if (rd_seen) check(reg_rdata, q.pop_front(), "reg_rdata");
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        report_and_stop();
    end
    // ====================================
    // scenarios
    initial begin
        core_cmd_t   c;
        logic [15:0] d;
        logic [4:0]  s;
        logic [31:0] acc, t;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        bus(1'b0, REG_MASK, 16'h0000);
        bus(1'b0, REG_FLAG, 16'h0000);
        bus(1'b0, REG_GSIZE, {8'h00, GSIZE_RESET});
        d = 16'(xs());
        bus(1'b1, REG_GSIZE, d);
        bus(1'b0, REG_GSIZE, {8'h00, d[7:0]});
        for (int i = 0; i < 6; i++) begin
            d = 16'(xs());
            s = (i == 0) ? 5'd16 : 5'(xs() % 17);
            acc = {16'h0000, d} << s;
            t = acc << i;
            c = '0;
            c.alu_op = ALU_LOAD;
            c.ishift = s;
            c.mpy_go = 1'b1;
            data_in <= d;
            op(c);
            c = '0;
            c.alu_op = ALU_ADD;
            c.src_prod = 1'b1;
            c.oshift = 3'(i);
            c.out_high = i[0];
            op(c);
            acc += 32'(d) * 32'(d);
            @(negedge clk_sys);
            check(dwb, i[0] ? t[31:16] : t[15:0], "data_write_bus");
            bus(1'b0, REG_ACC_LO, acc[15:0]);
            bus(1'b0, REG_ACC_HI, acc[31:16]);
        end
        c = '0;
        c.dp_load = 1'b1;
        c.dp_val = 9'h1ff;
        op(c);
        for (int i = 0; i < 2; i++) begin
            d = 16'(xs());
            c = '0;
            c.mem_go = 1'b1;
            c.direct = 1'b1;
            c.ir_low = 7'h05;
            op(c);
            data_in <= d;
            wait_cycles <= 4'(i * 6);
            @(negedge clk_sys);
            check(16'(gbr), 16'h1, "global_bus_request");
            check(dadr, 16'hff85, "data_addr");
            for (int k = 0; k < 40 && gbr !== 1'b0; k++) @(negedge clk_sys);
            check(16'(gbr), 16'h0, "request_release");
            check(drd, d, "data_read");
        end
        bus(1'b1, REG_CTRL, 16'h0000);
        bus(1'b1, REG_MASK, 16'h0004);
        c = '0;
        c.idle_req = 1'b1;
        op(c);
        irq_pin <= 7'h02;
        repeat (10) @(negedge clk_sys);
        check(16'(cpu_en), 16'h0, "masked_wake");
        bus(1'b0, REG_FLAG, 16'h0002);
        irq_pin <= 7'h06;
        for (int k = 0; k < 20 && cpu_en !== 1'b1; k++) @(negedge clk_sys);
        check(16'(cpu_en), 16'h1, "light_wake");
        @(posedge clk_sys);
        irq_pin <= 7'h00;
        repeat (4) @(posedge clk_sys);
        bus(1'b1, REG_FLAG, 16'h007f);
        bus(1'b0, REG_FLAG, 16'h0000);
        bus(1'b1, REG_CTRL, 16'h0008);
        op(c);
        irq_pin <= 7'h04;
        repeat (30) @(negedge clk_sys);
        check(16'(cpu_en), 16'h0, "halt_hold");
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        check(16'(cpu_en), 16'h1, "halt_reset");
        report_and_stop();
    end
endmodule
`default_nettype wire
